// File: dec_pkg.sv
// Package for the DMA channel event-control block.
// Assumes a single 200 MHz core clock domain and Avalon-MM register access.
package dec_pkg;
   // -----------------------------------------------------------------
   // Register offsets (byte addresses)
   // -----------------------------------------------------------------
   localparam logic [3:0] DEC_OFF_ECON = 4'h0;
   localparam logic [3:0] DEC_OFF_STATUS = 4'h4;
   localparam logic [3:0] DEC_OFF_MASK = 4'h8;
   localparam logic [3:0] DEC_OFF_CHCTL = 4'hC;
   // -----------------------------------------------------------------
   // Event-control field positions
   // -----------------------------------------------------------------
   localparam int DEC_ABORT_SEL_LSB = 16;
   localparam int DEC_START_SEL_LSB = 8;
   localparam int DEC_FORCE_BIT = 7;
   localparam int DEC_ABORT_BIT = 6;
   localparam int DEC_PATTERN_ABORT_ENABLE_BIT = 5;
   localparam int DEC_START_IRQ_ENABLE_BIT = 4;
   localparam int DEC_ABORT_IRQ_ENABLE_BIT = 3;
   // Status/mask bit positions
   localparam int DEC_ST_ABORT_IRQ = 0;
   localparam int DEC_ST_START = 1;
   localparam int DEC_ST_PATTERN = 2;
   localparam int DEC_ST_WIDTH = 3;
   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [7:0] DEC_SEL_RST = 8'hFF;
   localparam logic [2:0] DEC_EN_RST = 3'h0;
   localparam logic [DEC_ST_WIDTH-1:0] DEC_MASK_RST = 3'h0;
   localparam logic DEC_CHON_RST = 1'b0;
   // Bus response latency in cycles after request
   localparam int DEC_BUS_WAIT = 1;
endpackage

// File: dec_event_match.sv
// Event matcher: compares an interrupt request number with a selector.
// Assumes the request strobe is a single-cycle pulse from same-clock logic.
`timescale 1ns/100ps
`default_nettype none
module dec_event_match
   import dec_pkg::*;
(
   input wire logic [7:0] irq_num,    // Request number
   input wire logic irq_valid,        // Request strobe
   input wire logic [7:0] sel,        // Selected number
   input wire logic enable,           // Match enable
   output logic hit                   // Qualified match
);
   assign hit = irq_valid & enable & (irq_num == sel);
endmodule
`default_nettype wire

// File: dec_avmm_slave.sv
// Avalon-MM slave front end: one wait state, then a one-cycle access pulse.
// Assumes the master holds its request until waitrequest is seen low.
`timescale 1ns/100ps
`default_nettype none
module dec_avmm_slave
   import dec_pkg::*;
(
   input wire logic core_clk,         // Clock
   input wire logic rst_n,            // Async reset
   input wire logic avs_read,         // Read request
   input wire logic avs_write,        // Write request
   output logic avs_waitrequest,      // Stall
   output logic acc_rd,               // Read pulse
   output logic acc_wr                // Write pulse
);
   logic wait_done_reg;
   wire req = avs_read | avs_write;
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         wait_done_reg <= 1'b0;
      else
         wait_done_reg <= req & ~wait_done_reg;
   end
   assign avs_waitrequest = req & ~wait_done_reg;
   assign acc_rd = avs_read & wait_done_reg;
   assign acc_wr = avs_write & wait_done_reg;
endmodule
`default_nettype wire

// File: dec_channel_event_control.sv
// DMA channel event-control block with register file and interrupt.
// Assumes irq_num/irq_valid come from same-clock interrupt logic and the
// transfer engine accepts one-cycle start and abort pulses.
// -----------------------------------------------------------------
// -----------------------------------------------------------------
//
// Our own choices: register access over Avalon-MM and the address map.
`timescale 1ns/100ps
`default_nettype none
module dec_channel_event_control
   import dec_pkg::*;
(
   input wire logic core_clk,            // 200 MHz clock
   input wire logic rst_n,               // Async reset, active low
   input wire logic [3:0] avs_address,   // Byte address
   input wire logic avs_read,            // Read strobe
   input wire logic avs_write,           // Write strobe
   input wire logic [31:0] avs_writedata, // Write data
   input wire logic [3:0] avs_byteenable, // Byte lanes
   output logic [31:0] avs_readdata,     // Read data
   output logic avs_waitrequest,         // Stall
   input wire logic [7:0] irq_num,       // Interrupt number
   input wire logic irq_valid,           // Interrupt strobe
   input wire logic pattern_match,       // Pattern match pulse
   output logic xfer_start,              // Start command pulse
   output logic xfer_abort,              // Abort command pulse
   output logic channel_on,              // Channel enable level
   output logic irq_out                  // Interrupt level
);
   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   logic [7:0] abort_irq_select_reg;
   logic [7:0] start_irq_select_reg;
   logic pattern_abort_enable_reg;
   logic start_irq_enable_reg;
   logic abort_irq_enable_reg;
   logic channel_on_reg;
   logic [DEC_ST_WIDTH-1:0] status_reg;
   logic [DEC_ST_WIDTH-1:0] mask_reg;
   logic xfer_start_reg;
   logic xfer_abort_reg;
   logic [31:0] rdata_reg;
   logic acc_rd;
   logic acc_wr;
   logic start_hit;
   logic abort_hit;

   // -----------------------------------------------------------------
   // Bus front end and decode
   // -----------------------------------------------------------------
   dec_avmm_slave u_slave (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_waitrequest(avs_waitrequest),
      .acc_rd(acc_rd),
      .acc_wr(acc_wr)
   );

   // Offset decode shared by all register selects
   function automatic logic addr_is(input logic [3:0] addr, input logic [3:0] off);
      return addr == off;
   endfunction

   wire sel_econ = addr_is(avs_address, DEC_OFF_ECON);
   wire sel_status = addr_is(avs_address, DEC_OFF_STATUS);
   wire sel_mask = addr_is(avs_address, DEC_OFF_MASK);
   wire sel_chctl = addr_is(avs_address, DEC_OFF_CHCTL);
   wire wr_econ = acc_wr & sel_econ;
   wire wr_b0 = wr_econ & avs_byteenable[0];
   wire wr_b1 = wr_econ & avs_byteenable[1];
   wire wr_b2 = wr_econ & avs_byteenable[2];
   wire wr_mask = acc_wr & sel_mask & avs_byteenable[0];
   wire wr_chctl = acc_wr & sel_chctl & avs_byteenable[0];
   wire rd_status = acc_rd & sel_status;

   // -----------------------------------------------------------------
   // Event detection
   // -----------------------------------------------------------------
   dec_event_match u_start_match (
      .irq_num(irq_num),
      .irq_valid(irq_valid),
      .sel(start_irq_select_reg),
      .enable(start_irq_enable_reg),
      .hit(start_hit)
   );
   dec_event_match u_abort_match (
      .irq_num(irq_num),
      .irq_valid(irq_valid),
      .sel(abort_irq_select_reg),
      .enable(abort_irq_enable_reg),
      .hit(abort_hit)
   );

   wire force_wr = wr_b0 & avs_writedata[DEC_FORCE_BIT];
   wire abort_wr = wr_b0 & avs_writedata[DEC_ABORT_BIT];
   wire pat_hit = pattern_match & pattern_abort_enable_reg;
   wire abort_any = abort_hit | abort_wr | pat_hit;
   // Abort wins over a simultaneous start
   wire start_any = (start_hit | force_wr) & ~abort_any;
   wire [DEC_ST_WIDTH-1:0] st_events = {pat_hit, start_any, abort_hit};
   // Read clears only the bits it returned; an event in the wait cycle survives
   wire [DEC_ST_WIDTH-1:0] st_clear = rd_status ? rdata_reg[DEC_ST_WIDTH-1:0] : '0;

   // -----------------------------------------------------------------
   // Control register
   // -----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         abort_irq_select_reg <= DEC_SEL_RST;
         start_irq_select_reg <= DEC_SEL_RST;
         {pattern_abort_enable_reg, start_irq_enable_reg, abort_irq_enable_reg} <= DEC_EN_RST;
      end
      else
      begin
         if (wr_b2)
            abort_irq_select_reg <= avs_writedata[DEC_ABORT_SEL_LSB +: 8];
         if (wr_b1)
            start_irq_select_reg <= avs_writedata[DEC_START_SEL_LSB +: 8];
         if (wr_b0)
         begin
            pattern_abort_enable_reg <= avs_writedata[DEC_PATTERN_ABORT_ENABLE_BIT];
            start_irq_enable_reg <= avs_writedata[DEC_START_IRQ_ENABLE_BIT];
            abort_irq_enable_reg <= avs_writedata[DEC_ABORT_IRQ_ENABLE_BIT];
         end
      end
   end

   // Channel on: pattern abort clears it, and wins over a write
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         channel_on_reg <= DEC_CHON_RST;
      else if (pat_hit)
         channel_on_reg <= 1'b0;
      else if (wr_chctl)
         channel_on_reg <= avs_writedata[0];
   end

   // Command pulses to the transfer engine
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         xfer_start_reg <= 1'b0;
         xfer_abort_reg <= 1'b0;
      end
      else
      begin
         xfer_start_reg <= start_any;
         xfer_abort_reg <= abort_any;
      end
   end

   // -----------------------------------------------------------------
   // Status, mask and interrupt; event set wins over read clear
   // -----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         status_reg <= '0;
         mask_reg <= DEC_MASK_RST;
      end
      else
      begin
         status_reg <= (status_reg & ~st_clear) | st_events;
         if (wr_mask)
            mask_reg <= avs_writedata[DEC_ST_WIDTH-1:0];
      end
   end

   // -----------------------------------------------------------------
   // Read data
   // -----------------------------------------------------------------
   wire [31:0] econ_rd = {8'h00, abort_irq_select_reg, start_irq_select_reg,
                          2'b00,
                          pattern_abort_enable_reg, start_irq_enable_reg, abort_irq_enable_reg,
                          3'b000};
   wire [31:0] rd_mux = sel_econ ? econ_rd :
                        sel_status ? {29'h0, status_reg} :
                        sel_mask ? {29'h0, mask_reg} :
                        sel_chctl ? {31'h0, channel_on_reg} : 32'h0000_0000;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         rdata_reg <= 32'h0000_0000;
      else if (avs_read & avs_waitrequest)
         rdata_reg <= rd_mux;
   end

   assign avs_readdata = rdata_reg;
   assign xfer_start = xfer_start_reg;
   assign xfer_abort = xfer_abort_reg;
   assign channel_on = channel_on_reg;
   assign irq_out = |(status_reg & mask_reg);

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   sequence s_abort_irq;
      irq_valid && abort_irq_enable_reg && irq_num == abort_irq_select_reg;
   endsequence
   sequence s_start_irq;
      irq_valid && start_irq_enable_reg && irq_num == start_irq_select_reg && !abort_any;
   endsequence

   a_abort_on_irq: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_abort_irq |=> xfer_abort && status_reg[DEC_ST_ABORT_IRQ])
      else $error("abort irq did not abort");
   a_start_on_irq: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_start_irq |=> xfer_start)
      else $error("start irq did not start");
   a_start_ignored: assert property (@(posedge core_clk) disable iff (!rst_n)
      !start_irq_enable_reg && !force_wr |=> !xfer_start)
      else $error("start while disabled");
   a_abort_ignored: assert property (@(posedge core_clk) disable iff (!rst_n)
      !abort_irq_enable_reg && !abort_wr && !pat_hit |=> !xfer_abort)
      else $error("abort while disabled");
   a_force_start: assert property (@(posedge core_clk) disable iff (!rst_n)
      force_wr && !abort_any |=> xfer_start)
      else $error("force did not start");
   a_sw_abort: assert property (@(posedge core_clk) disable iff (!rst_n)
      abort_wr |=> xfer_abort && !xfer_start)
      else $error("abort write ignored");
   a_pattern_abort: assert property (@(posedge core_clk) disable iff (!rst_n)
      pattern_match && pattern_abort_enable_reg |=> xfer_abort && !channel_on)
      else $error("pattern abort failed");
   a_pattern_off: assert property (@(posedge core_clk) disable iff (!rst_n)
      pattern_match && !pattern_abort_enable_reg && !abort_hit && !abort_wr |=> !xfer_abort)
      else $error("pattern acted while off");
   a_strobe_bits_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
      acc_rd && sel_econ |-> avs_readdata[7:6] == 2'b00 && avs_readdata[2:0] == 3'b000)
      else $error("strobe bits read nonzero");
   a_upper_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
      acc_rd && sel_econ |-> avs_readdata[31:24] == 8'h00)
      else $error("unimplemented bits nonzero");

   // -----------------------------------------------------------------
   // Bus, status and register hold assertions
   // -----------------------------------------------------------------
   sequence s_bus_wait;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence

   a_bus_one_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_bus_wait |=> !avs_waitrequest)
      else $error("more than one wait state");
   a_rdata_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      !(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
      else $error("read data changed between reads");
   a_status_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
      !rd_status |=> (status_reg & $past(status_reg)) == $past(status_reg))
      else $error("status bit lost without a read");
   a_status_set: assert property (@(posedge core_clk) disable iff (!rst_n)
      st_events != '0 |=> (status_reg & $past(st_events)) == $past(st_events))
      else $error("status event not recorded");
   a_read_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
      rd_status && st_events == '0 |=> (status_reg & $past(avs_readdata[DEC_ST_WIDTH-1:0])) == '0)
      else $error("status read did not clear");
   a_irq_masked: assert property (@(posedge core_clk) disable iff (!rst_n)
      mask_reg == '0 |-> !irq_out)
      else $error("interrupt with all masked");
   a_start_cause: assert property (@(posedge core_clk) disable iff (!rst_n)
      !start_hit && !force_wr |=> !xfer_start)
      else $error("start without cause");
   a_abort_cause: assert property (@(posedge core_clk) disable iff (!rst_n)
      !abort_hit && !abort_wr && !pat_hit |=> !xfer_abort)
      else $error("abort without cause");
   a_abort_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
      xfer_abort |-> !xfer_start)
      else $error("start and abort together");
   a_chon_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      wr_chctl && !pat_hit |=> channel_on == $past(avs_writedata[0]))
      else $error("channel on write lost");
   a_chon_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      !wr_chctl && !pat_hit |=> $stable(channel_on))
      else $error("channel on changed without cause");
   a_start_sel_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      !wr_b1 |=> $stable(start_irq_select_reg))
      else $error("start selector changed");
   a_abort_sel_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      !wr_b2 |=> $stable(abort_irq_select_reg))
      else $error("abort selector changed");
   a_enable_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      !wr_b0 |=> $stable({pattern_abort_enable_reg, start_irq_enable_reg, abort_irq_enable_reg}))
      else $error("enable bits changed");
   a_mask_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      !wr_mask |=> $stable(mask_reg))
      else $error("mask changed without write");
endmodule
`default_nettype wire

// File: dec_far_model.sv
// Far side of the block: interrupt sources and the transfer engine.
// Assumes the block's core clock and one-cycle command pulses.
`timescale 1ns/100ps
`default_nettype none
module dec_far_model
   import dec_pkg::*;
(
   input wire logic core_clk,   // Clock
   input wire logic rst_n,      // Async reset, active low
   output logic [7:0] irq_num,  // Request number
   output logic irq_valid,      // Request strobe
   output logic pattern_match,  // Pattern match pulse
   input wire logic xfer_start, // Start command
   input wire logic xfer_abort  // Abort command
);
   int starts = 0;
   int aborts = 0;
   initial
   begin
      irq_num = 8'h00;
      irq_valid = 1'b0;
      pattern_match = 1'b0;
   end
   // Number unqualified after the strobe: show the inverse
   task fire(input logic [7:0] n);
      @(posedge core_clk);
      irq_num <= n;
      irq_valid <= 1'b1;
      @(posedge core_clk);
      irq_valid <= 1'b0;
      irq_num <= ~n;
   endtask
   task pat();
      @(posedge core_clk);
      pattern_match <= 1'b1;
      @(posedge core_clk);
      pattern_match <= 1'b0;
   endtask
   // Transfer engine counts commands
   always @(posedge core_clk)
   begin
      if (rst_n === 1'b1 && xfer_start === 1'b1)
         starts++;
      if (rst_n === 1'b1 && xfer_abort === 1'b1)
         aborts++;
   end
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking bench for the channel event-control block.
// Assumes dec_far_model as the interrupt source and transfer engine.
`timescale 1ns/100ps
`default_nettype none
module tb
   import dec_pkg::*;
   ;
   logic core_clk, rst_n, avs_read, avs_write, avs_waitrequest;
   logic [3:0] avs_address, avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata;
   logic [7:0] irq_num, ss, sa, ot;
   logic irq_valid, pattern_match, xfer_start, xfer_abort, channel_on, irq_out;
   logic [31:0] rq[$];
   logic [1:0] eq[$];
   int mismatches = 0;
   int num_checks = 0;
   int seed = 63;
   dec_channel_event_control uut (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .irq_num(irq_num), .irq_valid(irq_valid), .pattern_match(pattern_match), .xfer_start(xfer_start),
      .xfer_abort(xfer_abort), .channel_on(channel_on), .irq_out(irq_out));
   dec_far_model far (.core_clk(core_clk), .rst_n(rst_n), .irq_num(irq_num), .irq_valid(irq_valid),
      .pattern_match(pattern_match), .xfer_start(xfer_start), .xfer_abort(xfer_abort));
   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   task chk(input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   task summarize();
      $display("checks=%0d mismatches=%0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
      @(posedge core_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= ~w;
      avs_writedata <= d;
      avs_byteenable <= be;
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0)
         @(posedge core_clk);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task rd(input logic [3:0] a, input logic [31:0] exp);
      rq.push_back(exp);
      bus(1'b0, a, 32'h0, 4'hF);
   endtask
   // Unimplemented bits always written as ones
   task econ(input logic [7:0] lo, input logic [1:0] ev);
      if (ev != 2'b00)
         eq.push_back(ev);
      bus(1'b1, DEC_OFF_ECON, {8'hFF, sa, ss, lo | 8'h07}, 4'hF);
   endtask
   task idle(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task tend(input string s);
      $display("test %s done", s);
   endtask
   // -----------------------------------------------------------------
   // Clock, watcher, watchdog
   // -----------------------------------------------------------------
   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
   begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
         chk(rq.pop_front(), avs_readdata);
      if (xfer_start === 1'b1 || xfer_abort === 1'b1)
         chk({30'h0, eq.pop_front()}, {30'h0, xfer_start, xfer_abort});
   end
   initial
   begin
      repeat (2000) @(posedge core_clk);
      mismatches++;
      summarize();
   end
   // -----------------------------------------------------------------
   // Tests
   // -----------------------------------------------------------------
   initial
   begin
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      rst_n = 1'b0;
      ss = 8'($random(seed));
      sa = ss + 8'h01;
      ot = ss + 8'h02;
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(DEC_OFF_ECON, 32'h00FF_FF00);
      rd(DEC_OFF_STATUS, 32'h0);
      rd(DEC_OFF_MASK, 32'h0);
      rd(DEC_OFF_CHCTL, 32'h0);
      rd(4'h2, 32'h0);
      tend("reset");
      bus(1'b1, DEC_OFF_CHCTL, 32'h1, 4'hF);
      bus(1'b1, DEC_OFF_MASK, 32'h1, 4'hF);
      rd(DEC_OFF_MASK, 32'h1);
      econ(8'h38, 2'b00);
      rd(DEC_OFF_ECON, {8'h00, sa, ss, 8'h38});
      eq.push_back(2'b10);
      far.fire(ss);
      idle(2);
      chk(32'h0, {31'h0, irq_out});
      far.fire(ot);
      eq.push_back(2'b01);
      far.fire(sa);
      idle(2);
      chk(32'h1, {31'h0, irq_out});
      rd(DEC_OFF_STATUS, 32'h3);
      idle(1);
      chk(32'h0, {31'h0, irq_out});
      chk(32'h1, {31'h0, channel_on});
      eq.push_back(2'b10);
      fork
         rd(DEC_OFF_STATUS, 32'h0);
         far.fire(ss);
      join
      rd(DEC_OFF_STATUS, 32'h2);
      eq.push_back(2'b01);
      far.pat();
      idle(2);
      chk(32'h0, {31'h0, channel_on});
      rd(DEC_OFF_STATUS, 32'h4);
      tend("enabled events");
      econ(8'h00, 2'b00);
      bus(1'b1, DEC_OFF_CHCTL, 32'h1, 4'hF);
      far.fire(ss);
      far.fire(sa);
      far.pat();
      idle(3);
      chk(32'h1, {31'h0, channel_on});
      rd(DEC_OFF_STATUS, 32'h0);
      tend("disabled events");
      econ(8'h80, 2'b10);
      econ(8'h40, 2'b01);
      econ(8'hC0, 2'b01);
      rd(DEC_OFF_ECON, {8'h00, sa, ss, 8'h00});
      bus(1'b1, DEC_OFF_ECON, {16'hFFFF, ot, 8'hFF}, 4'h2);
      rd(DEC_OFF_ECON, {8'h00, sa, ot, 8'h00});
      rd(DEC_OFF_STATUS, 32'h2);
      idle(3);
      chk(32'h0, 32'(eq.size()));
      chk(32'h3, 32'(far.starts));
      chk(32'h4, 32'(far.aborts));
      tend("strobes");
      summarize();
   end
endmodule
`default_nettype wire
